/* shared/failsafe_out_defines.svh */
// Offsets, field positions, reset values and timing counts of the failsafe block.
`ifndef FAILSAFE_OUT_DEFINES_SVH
`define FAILSAFE_OUT_DEFINES_SVH

`define ADDR_CTRL        8'h00
`define ADDR_SAFE_SEL    8'h04
`define ADDR_SRC0        8'h08
`define ADDR_SRC1        8'h0C
`define ADDR_SRC2        8'h10
`define ADDR_SRC3        8'h14
`define ADDR_RETRACT     8'h18
`define ADDR_OUT_STATUS  8'h1C
`define ADDR_RB_STATUS   8'h20
`define ADDR_STOP_STATUS 8'h24

`define CTRL_RESPONSE    0
`define CTRL_EXT_REL     1
`define CTRL_ESR_ACT     2
`define CTRL_ESR_EN      3
`define CTRL_SRC_VALID   4
`define CTRL_FAULT_ACK   5

`define STAT_RETRACT_BIT 14
`define RETRACT_MAX_MS   800
`define CLK_KHZ          10000
`define RETRACT_MAX_CYC  (`RETRACT_MAX_MS * `CLK_KHZ)
`define SRC_RESET        32'h0000_0000

`endif

/* shared/failsafe_out_pkg.sv */
// Types shared by the failsafe output block.
package failsafe_out_pkg;
    typedef enum logic [1:0] {STOP_NONE, STOP_IMMEDIATE, STOP_RAMPED,
                              STOP_RETRACT} stop_e;
    typedef enum {RUN, RETRACT_WAIT, TORQUE_OFF, RAMP, FAULT} fail_state_e;
    // Source code: bits [5:4] group, bits [3:0] signal index, 8'hFF unused.
    typedef logic [7:0] src_sel_t;
endpackage : failsafe_out_pkg

/* rtl/failsafe_out.sv */
// Failsafe outputs and communication-fault stop response.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`include "failsafe_out_defines.svh"
module failsafe_out
    import failsafe_out_pkg::*;
#(
    parameter int unsigned RETRACT_MAX_CYCLES = `RETRACT_MAX_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Per-drive safety signals, 4 groups x 4 drives x 16 signals
    input  wire logic [15:0] driveSig [4][4],
    input  wire logic [3:0]  driveMember [4],
    // Failure and link-status inputs from link monitors, fault acknowledge (pins)
    input  wire logic        fieldbusFail,
    input  wire logic        controllerStopped,
    input  wire logic        moduleLinkFail,
    input  wire logic        motionLinkOk,
    input  wire logic        eventAckIn,
    // Output switching stages and readback pins
    output logic [3:0]       outPos,
    output logic [3:0]       outGnd,
    input  wire logic [3:0]  readbackIn,
    // Stop response
    output logic             torqueOff,
    output logic             rampStop,
    output logic [15:0]      extendedSafetyStatus,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int unsigned CLK_KHZ = `CLK_KHZ;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Pin synchronisers.
    logic [3:0] pinMeta_r, pinSync_r, rbMeta_r, rbSync_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta_r <= 4'h0;
            pinSync_r <= 4'h0;
            rbMeta_r  <= 4'h0;
            rbSync_r  <= 4'h0;
        end
        else
        begin
            pinMeta_r <= {eventAckIn, moduleLinkFail, controllerStopped,
                          fieldbusFail};
            pinSync_r <= pinMeta_r;
            rbMeta_r  <= readbackIn;
            rbSync_r  <= rbMeta_r;
        end
    end

    // Registers.
    logic [31:0] ctrl_r, safeSel_r, retract_r;
    logic [31:0] src_r [4];
    logic        commFault_r, ackPrev_r;
    fail_state_e state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [3:0]  outStat_r;

    // Signal index 7 is the group safe state; 0..6 feed it.
    function automatic logic pick(input logic [15:0] grp [4],
                                  input src_sel_t sel);
        if (sel == 8'hFF)
            return 1'b1;
        return grp[sel[5:4]][sel[3:0]];
    endfunction : pick

    logic [15:0] grpSig [4];
    always_comb
    begin
        for (int g = 0; g < 4; g++)
        begin
            logic [15:0] acc;
            acc = 16'hFFFF;
            for (int d = 0; d < 4; d++)
                if (driveMember[g][d])
                    acc = acc & driveSig[g][d];
            acc[7] = |(acc[6:0] & safeSel_r[g*8 +: 7]);
            grpSig[g] = acc;
        end
    end

    logic [3:0] outVal;
    always_comb
    begin
        for (int o = 0; o < 4; o++)
        begin
            outVal[o] = ctrl_r[`CTRL_SRC_VALID];
            for (int k = 0; k < 4; k++)
                outVal[o] = outVal[o] & pick(grpSig, src_r[o][k*8 +: 8]);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            outStat_r <= 4'h0;
        else
            outStat_r <= outVal;
    end
    assign outPos = outStat_r;
    assign outGnd = outStat_r;

    // Communication fault and its response.
    logic commFail;
    assign commFail = pinSync_r[0] | pinSync_r[1] | pinSync_r[2];
    logic ackFall;
    assign ackFall = ackPrev_r & ~pinSync_r[3];

    logic [31:0] retractCyc;
    always_comb
    begin
        logic [31:0] ms;
        ms = (retract_r > `RETRACT_MAX_MS) ? `RETRACT_MAX_MS : retract_r;
        retractCyc = ms * CLK_KHZ;
        if (retractCyc > RETRACT_MAX_CYCLES)
            retractCyc = RETRACT_MAX_CYCLES;
    end

    logic escEn, rampOk;
    assign escEn  = ctrl_r[`CTRL_ESR_ACT] & ctrl_r[`CTRL_ESR_EN];
    assign rampOk = ctrl_r[`CTRL_RESPONSE] & ctrl_r[`CTRL_EXT_REL];

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            RUN:
                if (commFail)
                begin
                    cnt_nxt = 32'h0;
                    if (escEn)
                        state_nxt = RETRACT_WAIT;
                    else if (rampOk)
                        state_nxt = RAMP;
                    else
                        state_nxt = TORQUE_OFF;
                end
            RETRACT_WAIT:
                if (cnt_r + 32'h1 >= retractCyc)
                    state_nxt = TORQUE_OFF;
                else
                    cnt_nxt = cnt_r + 32'h1;
            TORQUE_OFF, RAMP:
                state_nxt = FAULT;
            FAULT:
                state_nxt = FAULT;
            default:
                state_nxt = TORQUE_OFF;
        endcase
        // ack falling edge while confirm bit is set and no comm failure releases the fault.
        if (state_r == FAULT && !commFail && ackFall && ctrl_r[`CTRL_FAULT_ACK])
            state_nxt = RUN;
    end

    logic stoSticky_r, rampSticky_r;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r      <= RUN;
            cnt_r        <= 32'h0;
            commFault_r  <= 1'b0;
            ackPrev_r    <= 1'b0;
            stoSticky_r  <= 1'b0;
            rampSticky_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            commFault_r <= commFail;
            ackPrev_r   <= pinSync_r[3];
            if (state_nxt == RUN)
            begin
                stoSticky_r  <= 1'b0;
                rampSticky_r <= 1'b0;
            end
            else
            begin
                if (state_nxt == TORQUE_OFF)
                    stoSticky_r <= 1'b1;
                if (state_nxt == RAMP)
                    rampSticky_r <= 1'b1;
            end
        end
    end
    assign torqueOff = stoSticky_r;
    assign rampStop  = rampSticky_r;
    always_comb
    begin
        extendedSafetyStatus = 16'h0;
        extendedSafetyStatus[`STAT_RETRACT_BIT] =
            (state_r == RETRACT_WAIT) & motionLinkOk;
    end

    // AXI4-Lite slave; single-word registers, write when both channels seen.
    logic        awHeld_r, wHeld_r;
    logic [7:0]  awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_rresp   = 2'h0;
    assign s_axi_arready = ~s_axi_rvalid;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        for (int b = 0; b < 4; b++)
            if (s[b])
                old[b*8 +: 8] = d[b*8 +: 8];
        return old;
    endfunction : merge

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            awAddr_r     <= 8'h00;
            wData_r      <= 32'h0;
            wStrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            ctrl_r       <= 32'h0;
            safeSel_r    <= 32'h0;
            retract_r    <= 32'h0;
            for (int i = 0; i < 4; i++)
                src_r[i] <= `SRC_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (awHeld_r && wHeld_r)
            begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awAddr_r)
                    `ADDR_CTRL:     ctrl_r    <= merge(ctrl_r, wData_r, wStrb_r);
                    `ADDR_SAFE_SEL: safeSel_r <= merge(safeSel_r, wData_r,
                                                       wStrb_r);
                    `ADDR_SRC0:     src_r[0]  <= merge(src_r[0], wData_r, wStrb_r);
                    `ADDR_SRC1:     src_r[1]  <= merge(src_r[1], wData_r, wStrb_r);
                    `ADDR_SRC2:     src_r[2]  <= merge(src_r[2], wData_r, wStrb_r);
                    `ADDR_SRC3:     src_r[3]  <= merge(src_r[3], wData_r, wStrb_r);
                    `ADDR_RETRACT:  retract_r <= merge(retract_r, wData_r,
                                                       wStrb_r);
                    default:        ;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    `ADDR_CTRL:        s_axi_rdata <= ctrl_r;
                    `ADDR_SAFE_SEL:    s_axi_rdata <= safeSel_r;
                    `ADDR_SRC0:        s_axi_rdata <= src_r[0];
                    `ADDR_SRC1:        s_axi_rdata <= src_r[1];
                    `ADDR_SRC2:        s_axi_rdata <= src_r[2];
                    `ADDR_SRC3:        s_axi_rdata <= src_r[3];
                    `ADDR_RETRACT:     s_axi_rdata <= retract_r;
                    `ADDR_OUT_STATUS:  s_axi_rdata <= {28'h0, outStat_r};
                    `ADDR_RB_STATUS:   s_axi_rdata <= {28'h0, rbSync_r};
                    `ADDR_STOP_STATUS: s_axi_rdata <= {29'h0, stoSticky_r,
                                                       rampSticky_r,
                                                       commFault_r};
                    default:           s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    chk_outputs_off_reset: assert property (
        !ctrl_r[`CTRL_SRC_VALID] |=> outPos == 4'h0)
        else $error("output energized without valid sources");
    chk_stop_immediate: assert property (
        state_r == RUN && commFail && !escEn && !rampOk |=> torqueOff)
        else $error("no immediate stop on comm failure");
    chk_ramp_gated: assert property (
        $rose(rampStop) |-> $past(rampOk))
        else $error("ramped stop without release");
    chk_retract_expire: assert property (
        state_r == RETRACT_WAIT && cnt_r + 32'h1 >= retractCyc |=> torqueOff)
        else $error("torque off missing after retract delay");
    chk_retract_gated: assert property (
        $rose(state_r == RETRACT_WAIT) |-> $past(escEn))
        else $error("retract without module enabled");
    chk_retract_bit: assert property (
        extendedSafetyStatus[`STAT_RETRACT_BIT] |-> state_r == RETRACT_WAIT)
        else $error("retract request out of delay");
    chk_pos_gnd_pair: assert property (
        outPos == outGnd)
        else $error("switching stages disagree");
    chk_out_and: assert property (
        outPos == $past(outVal))
        else $error("output not AND of sources");
endmodule : failsafe_out

/* test/safety_ctrl_model.sv */
// Behavioural model of the higher-level safety controller on the bus.
module safety_ctrl_model
(
    // Clock
    input  wire logic        ref_clk,
    // Scenario: 0 healthy, 1 disturbed, 2 stopped, 3 disturbed, no motion
    input  wire logic [1:0]  mode,
    // Block side
    input  wire logic [15:0] extendedSafetyStatus,
    output logic             fieldbusFail,
    output logic             controllerStopped,
    output logic             motionLinkOk,
    output logic             retractDone
);
    timeunit 1ns;
    timeprecision 1ns;
    assign fieldbusFail      = mode[0];
    assign controllerStopped = (mode == 2'h2);
    assign motionLinkOk      = (mode != 2'h3);
    // The controller can only retract while it still hears the drive.
    always_ff @(posedge ref_clk)
        retractDone <= extendedSafetyStatus[14] && motionLinkOk;
endmodule : safety_ctrl_model

/* test/failsafe_output_and_comm_fault_response_tb_top.sv */
// Self-checking bench for the failsafe outputs and comm-fault stops.
`include "failsafe_out_defines.svh"
module failsafe_output_and_comm_fault_response_tb_top
    import failsafe_out_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, rst, moduleLinkFail, eventAckIn, retractDone;
    logic [15:0] driveSig [4][4];
    logic [3:0]  driveMember [4];
    logic        fieldbusFail, controllerStopped, motionLinkOk;
    logic [3:0]  outPos, outGnd, readbackIn, s_axi_wstrb;
    logic        torqueOff, rampStop;
    logic [15:0] extendedSafetyStatus;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv, tmp, safeSel;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, pmode;
    logic [7:0]  srcCode [4][4];
    logic [7:0]  ctrlTab [8] = '{8'h10, 8'h10, 8'h10, 8'h13, 8'h11, 8'h14,
                                 8'h1C, 8'h1C};
    logic [1:0]  modeTab [8] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
                                 2'h3};
    logic [2:0]  expTab [8]  = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h4, 3'h4, 3'h1,
                                 3'h0};
    int          seed, err_count, compares, n6, n7;

    failsafe_out #(.RETRACT_MAX_CYCLES(100)) failsafe_out_inst (.ref_clk,
        .rst, .driveSig, .driveMember, .fieldbusFail, .controllerStopped,
        .moduleLinkFail, .motionLinkOk, .eventAckIn, .outPos, .outGnd,
        .readbackIn, .torqueOff, .rampStop, .extendedSafetyStatus,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    safety_ctrl_model safety_ctrl_model_inst (.ref_clk, .mode(pmode),
        .extendedSafetyStatus, .fieldbusFail, .controllerStopped,
        .motionLinkOk, .retractDone);

    task automatic report_and_stop();
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_up();
        err_count++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask : give_up

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        if (n >= 50)
            give_up();
    endtask : axi_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        int n;
        @(posedge ref_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        rdv = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n >= 50)
            give_up();
        check(rdv, exp);
        check({30'h0, s_axi_rresp}, 32'h0);
    endtask : rd_chk

    task automatic wait_sto(output int n);
        for (n = 0; n < 300 && torqueOff !== 1'b1; n++)
            @(posedge ref_clk);
        if (n >= 300)
            give_up();
    endtask : wait_sto

    // Group signal: AND over member drives; index 7 is the group safe state.
    function automatic logic grp(int g, int i);
        logic r;
        r = (i != 7);
        for (int k = 0; k < 7 && i == 7; k++)
            r |= safeSel[8*g+k] & grp(g, k);
        for (int d = 0; d < 4 && i != 7; d++)
            if (driveMember[g][d])
                r &= driveSig[g][d][i];
        return r;
    endfunction : grp

    function automatic logic [31:0] exp_out(logic valid);
        logic [31:0] r;
        r = 32'h0;
        for (int o = 0; o < 4; o++)
        begin
            r[o] = valid;
            for (int s = 0; s < 4; s++)
                if (srcCode[o][s] !== 8'hFF)
                    r[o] &= grp(srcCode[o][s][5:4], srcCode[o][s][3:0]);
        end
        return r;
    endfunction : exp_out

    initial
    begin
        ref_clk = 1'b0;
        forever
            #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        seed = 94;
        err_count = 0;
        compares = 0;
        rst = 1'b1;
        {moduleLinkFail, eventAckIn, pmode, readbackIn} = 8'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        foreach (driveSig[g, d])
            driveSig[g][d] = 16'h0000;
        foreach (driveMember[g])
            driveMember[g] = 4'hF;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        check({28'h0, outPos | outGnd | {torqueOff, rampStop}}, 32'h0);
        for (int it = 0; it < 30; it++)
        begin
            safeSel = $random(seed) & 32'h7F7F7F7F;
            foreach (srcCode[o, s])
            begin
                tmp = $random(seed);
                srcCode[o][s] = (s > 0 && tmp[9:8] == 2'h0) ? 8'hFF :
                    {2'h0, tmp[5:4], (tmp[3:0] == 4'hF) ? 4'h7 : tmp[3:0]};
            end
            foreach (driveSig[g, d])
                driveSig[g][d] <= 16'($random(seed));
            foreach (driveMember[g])
                driveMember[g] <= 4'($random(seed)) | 4'h1;
            readbackIn <= 4'($random(seed));
            axi_write(`ADDR_SAFE_SEL, safeSel);
            for (int o = 0; o < 4; o++)
                axi_write(8'(`ADDR_SRC0 + 4 * o), {srcCode[o][3],
                    srcCode[o][2], srcCode[o][1], srcCode[o][0]});
            if (it == 1)
                axi_write(`ADDR_CTRL, 32'h0000_0010);
            repeat (4) @(posedge ref_clk);
            check({28'h0, outPos}, exp_out(it > 0));
            check({28'h0, outGnd}, exp_out(it > 0));
            rd_chk(`ADDR_OUT_STATUS, exp_out(it > 0));
            rd_chk(`ADDR_RB_STATUS, {28'h0, readbackIn});
        end
        axi_write(8'h80, 32'hFFFFFFFF);
        rd_chk(8'h80, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            rst <= 1'b1;
            pmode <= 2'h0;
            moduleLinkFail <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rst <= 1'b0;
            // Overlong delay on the last case must be held to the maximum.
            axi_write(`ADDR_RETRACT, (c == 7) ? 32'h3E8 : 32'h320);
            axi_write(`ADDR_CTRL, {24'h0, ctrlTab[c]});
            pmode <= modeTab[c];
            moduleLinkFail <= (c == 2);
            repeat (10) @(posedge ref_clk);
            check({torqueOff, rampStop, extendedSafetyStatus[14]},
                  expTab[c]);
            check({31'h0, retractDone}, {31'h0, expTab[c][0]});
            rd_chk(`ADDR_STOP_STATUS, {expTab[c][2:1], 1'b1});
            if (c == 0)
            begin
                pmode <= 2'h0;
                axi_write(`ADDR_CTRL, 32'h0000_0030);
                eventAckIn <= 1'b1;
                repeat (4) @(posedge ref_clk);
                eventAckIn <= 1'b0;
                repeat (8) @(posedge ref_clk);
                check({31'h0, torqueOff}, 32'h0);
            end
            if (c == 6)
                wait_sto(n6);
            if (c == 7)
                wait_sto(n7);
        end
        check(32'(n6 > 60), 32'h1);
        check(32'(n7 <= n6 + 2), 32'h1);
        report_and_stop();
    end
endmodule : failsafe_output_and_comm_fault_response_tb_top
